// ---- verilog/dual_clock_fifo.sv ----
/*
  512 x 18 fifo with sampled write and read clocks, status flags,
  programmable almost threshold and an apb register window.
  assumes write_clock, read_clock and the data pins are slow against pclk
  and held steady for three pclk cycles after each rising clock edge.
*/
// The implementer's own choices: the APB slave port and the placing of the registers.
module dual_clock_fifo
  import fifo_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [APB_ADDR_WIDTH-1:0] paddr,
  input  wire logic [APB_DATA_WIDTH-1:0] pwdata,
  output logic      [APB_DATA_WIDTH-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      write_clock,
  input  wire logic                      read_clock,
  input  wire logic                      offset_program_n,
  input  wire logic [WORD_WIDTH-1:0]     write_data,
  input  wire logic                      output_enable_n,
  output logic      [WORD_WIDTH-1:0]     read_data,
  output logic                           read_data_oe_n,
  output logic                           full_flag_n,
  output logic                           empty_flag_n,
  output logic                           half_full_flag,
  output logic                           almost_threshold_flag
);

  localparam int PIN_WIDTH = WORD_WIDTH + 4;

  logic [PIN_WIDTH-1:0]   pins_sync;
  logic                   wclk_s;
  logic                   rclk_s;
  logic                   prog_n_s;
  logic                   oe_n_s;
  logic [WORD_WIDTH-1:0]  wdata_s;
  logic                   wclk_prev_r;
  logic                   rclk_prev_r;
  logic                   write_edge;
  logic                   read_edge;

  logic [PTR_WIDTH-1:0]   wgray_r;
  logic [PTR_WIDTH-1:0]   rgray_r;
  logic [PTR_WIDTH-1:0]   wbin;
  logic [PTR_WIDTH-1:0]   rbin;
  logic [PTR_WIDTH-1:0]   wbin_nxt;
  logic [PTR_WIDTH-1:0]   rbin_nxt;
  logic [PTR_WIDTH-1:0]   count;
  logic [PTR_WIDTH-1:0]   count_nxt;
  logic                   is_full;
  logic                   is_empty;
  logic                   write_do;
  logic                   read_do;
  logic                   prog_cycle;

  prog_state_type         prog_r;
  logic [OFFSET_WIDTH-1:0] ae_offset_r;
  logic [OFFSET_WIDTH-1:0] af_offset_r;
  logic [PTR_WIDTH-1:0]   af_limit;
  logic                   load_both;
  logic                   load_full;

  logic [1:0]             ctrl_r;
  logic                   flush;
  logic                   apb_access;
  logic                   apb_write;
  logic                   apb_commit;
  logic                   ctrl_hit;
  logic                   addr_ok;
  logic [APB_DATA_WIDTH-1:0] read_mux;

  logic [WORD_WIDTH-1:0]  store_word;
  logic                   head_bypass;
  logic [WORD_WIDTH-1:0]  head_word;

  // every pin passes two flops; data is delayed as much as the clocks
  input_sync #(
    .width       (PIN_WIDTH),
    .reset_value ({2'b11, {WORD_WIDTH{1'b0}}, 2'b00})
  ) u_pins (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({offset_program_n, output_enable_n, write_data, write_clock, read_clock}),
    .sync_out (pins_sync)
  );

  assign prog_n_s = pins_sync[PIN_WIDTH-1];
  assign oe_n_s   = pins_sync[PIN_WIDTH-2];
  assign wdata_s  = pins_sync[WORD_WIDTH+1:2];
  assign wclk_s   = pins_sync[1];
  assign rclk_s   = pins_sync[0];

  // previous samples reset to the idle low level, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_prev_r <= 1'b0;
    end else begin
      wclk_prev_r <= wclk_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rclk_prev_r <= 1'b0;
    end else begin
      rclk_prev_r <= rclk_s;
    end
  end

  // both clocks land in one sampled domain, so any phase relation is fine
  assign write_edge = wclk_s & ~wclk_prev_r;
  assign read_edge  = rclk_s & ~rclk_prev_r;

  // apb decode: first access cycle is the wait state, the second commits
  assign apb_access = psel & penable & ~pready;
  // writes land only at the edge where the master sees pready high
  assign apb_commit = psel & penable & pready;
  assign apb_write  = apb_commit & pwrite;
  assign ctrl_hit   = (paddr == CTRL_ADDR);
  assign addr_ok    = ctrl_hit | (paddr == STATUS_ADDR) | (paddr == OFFSET_ADDR);
  assign flush      = apb_write & ctrl_hit & pwdata[CTRL_FLUSH_BIT];

  // occupancy from gray pointers, decoded once per pointer
  assign wbin     = gray_to_bin(wgray_r);
  assign rbin     = gray_to_bin(rgray_r);
  assign count    = wbin - rbin;
  assign is_full  = (count == DEPTH_COUNT);
  assign is_empty = (count == '0);

  assign prog_cycle = write_edge & ~prog_n_s & (prog_r != PROG_DONE);
  // paused or programming write edges do not store
  assign write_do   = write_edge & ~is_full & ~prog_cycle & ~ctrl_r[CTRL_PAUSE_BIT];
  assign read_do    = read_edge & ~is_empty;

  assign wbin_nxt  = write_do ? wbin + 10'h001 : wbin;
  assign rbin_nxt  = read_do ? rbin + 10'h001 : rbin;
  assign count_nxt = wbin_nxt - rbin_nxt;

  // flush wins over a write or read edge in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wgray_r <= '0;
    end else if (flush) begin
      wgray_r <= '0;
    end else begin
      wgray_r <= bin_to_gray(wbin_nxt);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rgray_r <= '0;
    end else if (flush) begin
      rgray_r <= '0;
    end else begin
      rgray_r <= bin_to_gray(rbin_nxt);
    end
  end

  fifo_storage u_store (
    .clk         (pclk),
    .write_en    (write_do),
    .write_index (wbin[INDEX_WIDTH-1:0]),
    .write_word  (wdata_s),
    .read_index  (rbin_nxt[INDEX_WIDTH-1:0]),
    .read_word   (store_word)
  );

  // offset programming sequence
  // a program edge loads offsets instead of storing a word
  assign load_both = write_edge & ~prog_n_s & (prog_r == PROG_BOTH);
  assign load_full = write_edge & ~prog_n_s & (prog_r == PROG_FULL_ONLY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_r <= PROG_BOTH;
    end else if (flush) begin
      prog_r <= PROG_BOTH;
    end else if (write_edge) begin
      case (prog_r)
        PROG_BOTH: begin
          // pin high on the first edge: that edge writes, defaults stay
          prog_r <= prog_n_s ? PROG_DONE : PROG_FULL_ONLY;
        end
        PROG_FULL_ONLY: begin
          prog_r <= PROG_DONE;
        end
        PROG_DONE: begin
          prog_r <= PROG_DONE;
        end
        default: begin
          prog_r <= PROG_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ae_offset_r <= OFFSET_DEFAULT;
    end else if (flush) begin
      ae_offset_r <= OFFSET_DEFAULT;
    end else if (load_both) begin
      ae_offset_r <= wdata_s[OFFSET_WIDTH-1:0];
    end
  end

  // a second program edge moves only the full side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af_offset_r <= OFFSET_DEFAULT;
    end else if (flush) begin
      af_offset_r <= OFFSET_DEFAULT;
    end else if (load_both | load_full) begin
      af_offset_r <= wdata_s[OFFSET_WIDTH-1:0];
    end
  end

  // 8-bit offsets cap both at 255 by width
  assign af_limit = DEPTH_COUNT - {2'b00, af_offset_r};

  // flags from next occupancy so they move with the pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_flag_n <= 1'b1;
    end else if (flush) begin
      full_flag_n <= 1'b1;
    end else begin
      full_flag_n <= (count_nxt != DEPTH_COUNT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_flag_n <= 1'b0;
    end else if (flush) begin
      empty_flag_n <= 1'b0;
    end else begin
      empty_flag_n <= (count_nxt != '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_full_flag <= 1'b0;
    end else if (flush) begin
      half_full_flag <= 1'b0;
    end else begin
      half_full_flag <= (count_nxt >= HALF_COUNT);
    end
  end

  // both bands checked each cycle; with 8-bit offsets they never overlap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      almost_threshold_flag <= 1'b1;
    end else if (flush) begin
      almost_threshold_flag <= 1'b1;
    end else begin
      almost_threshold_flag <= (count_nxt <= {2'b00, ae_offset_r}) |
                               (count_nxt >= af_limit);
    end
  end

  // head word: a word written into the slot about to be shown bypasses storage
  assign head_bypass = write_do & (wbin[INDEX_WIDTH-1:0] == rbin_nxt[INDEX_WIDTH-1:0]);
  assign head_word   = head_bypass ? wdata_s : store_word;

  // read data has no reset on purpose; it holds when nothing is stored
  always_ff @(posedge pclk) begin
    if (count_nxt != '0) begin
      read_data <= head_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_data_oe_n <= 1'b1;
    end else begin
      read_data_oe_n <= oe_n_s;
    end
  end

  // control register: flush self-clears, pause stays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (apb_write & ctrl_hit) begin
      ctrl_r <= {pwdata[CTRL_PAUSE_BIT], 1'b0};
    end
  end

  always_comb begin
    read_mux = '0;
    case (paddr)
      CTRL_ADDR: begin
        read_mux[CTRL_PAUSE_BIT] = ctrl_r[CTRL_PAUSE_BIT];
      end
      STATUS_ADDR: begin
        read_mux[STATUS_COUNT_LSB +: PTR_WIDTH] = count;
        read_mux[STATUS_EMPTY_N_BIT] = empty_flag_n;
        read_mux[STATUS_FULL_N_BIT]  = full_flag_n;
        read_mux[STATUS_HALF_BIT]    = half_full_flag;
        read_mux[STATUS_ALMOST_BIT]  = almost_threshold_flag;
        read_mux[STATUS_PROG_LSB +: 2] = prog_r;
      end
      OFFSET_ADDR: begin
        read_mux[OFFSET_AE_LSB +: OFFSET_WIDTH] = ae_offset_r;
        read_mux[OFFSET_AF_LSB +: OFFSET_WIDTH] = af_offset_r;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  // one wait state keeps every apb output registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_access;
    end
  end

  // unmapped addresses answer with an error and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apb_access & ~addr_ok;
    end
  end

  // read data holds between reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (apb_access & ~pwrite) begin
      prdata <= read_mux;
    end
  end

endmodule

// ---- verilog/fifo_pkg.sv ----
/*
  constants, types and helper functions of the sampled dual-clock fifo.
  assumes one system clock domain (pclk) that samples both fifo clocks.
*/
// Behaviour
// - 18-bit words, independent write and read clocks
// - write edge stores word, read edge advances
// - full when written minus read is 512
// - write edge while full changes nothing
// - read edge while empty changes nothing
// - full flag low exactly when full
// - empty flag low exactly when empty
// - half flag high at 256 or more
// - program low: first edges set offsets
// - almost flag high near empty or full
// - almost flag low in middle band
// - reset clears pointers, sets flag levels
// - reset leaves read data undefined
// - first word into empty appears at once
// - output enable high floats read data; here only read_data_oe_n follows it, read_data stays driven
// - first program edge sets both offsets
// - second program edge sets full offset only
// - offsets max 255, default 64
package fifo_pkg;

  localparam int WORD_WIDTH  = 18;
  localparam int INDEX_WIDTH = 9;
  localparam int PTR_WIDTH   = 10;
  localparam int OFFSET_WIDTH = 8;

  localparam logic [PTR_WIDTH-1:0] DEPTH_COUNT      = 10'h200;
  localparam logic [PTR_WIDTH-1:0] HALF_COUNT       = 10'h100;
  localparam logic [OFFSET_WIDTH-1:0] OFFSET_DEFAULT = 8'h40;

  localparam int APB_ADDR_WIDTH = 8;
  localparam int APB_DATA_WIDTH = 32;
  localparam logic [APB_ADDR_WIDTH-1:0] CTRL_ADDR   = 8'h00;
  localparam logic [APB_ADDR_WIDTH-1:0] STATUS_ADDR = 8'h04;
  localparam logic [APB_ADDR_WIDTH-1:0] OFFSET_ADDR = 8'h08;

  localparam int CTRL_FLUSH_BIT = 0;
  localparam int CTRL_PAUSE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam int STATUS_COUNT_LSB = 0;
  localparam int STATUS_EMPTY_N_BIT = 16;
  localparam int STATUS_FULL_N_BIT = 17;
  localparam int STATUS_HALF_BIT = 18;
  localparam int STATUS_ALMOST_BIT = 19;
  localparam int STATUS_PROG_LSB = 20;
  localparam int OFFSET_AE_LSB = 0;
  localparam int OFFSET_AF_LSB = 8;

  typedef enum logic [1:0] {
    PROG_BOTH      = 2'b00,
    PROG_FULL_ONLY = 2'b01,
    PROG_DONE      = 2'b10
  } prog_state_type;

  function automatic logic [PTR_WIDTH-1:0] gray_to_bin(input logic [PTR_WIDTH-1:0] g);
    logic [PTR_WIDTH-1:0] b;
    b = '0;
    b[PTR_WIDTH-1] = g[PTR_WIDTH-1];
    for (int i = PTR_WIDTH - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction

  function automatic logic [PTR_WIDTH-1:0] bin_to_gray(input logic [PTR_WIDTH-1:0] b);
    return b ^ (b >> 1);
  endfunction

endpackage

// ---- verilog/input_sync.sv ----
/*
  two-flip-flop synchroniser for a group of pins.
  assumes the pins are steady long enough around each sampled edge.
*/
module input_sync
  import fifo_pkg::*;
#(
  parameter int               width       = 1,
  parameter logic [width-1:0] reset_value = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);

  logic [width-1:0] stage1_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= reset_value;
      sync_out <= reset_value;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule

// ---- verilog/fifo_storage.sv ----
/*
  flip-flop word store, one write port, one combinational read port.
  assumes write and read indices come from the same clock domain.
*/
module fifo_storage
  import fifo_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   write_en,
  input  wire logic [INDEX_WIDTH-1:0] write_index,
  input  wire logic [WORD_WIDTH-1:0]  write_word,
  input  wire logic [INDEX_WIDTH-1:0] read_index,
  output logic      [WORD_WIDTH-1:0]  read_word
);

  logic [WORD_WIDTH-1:0] mem_r [0:(1 << INDEX_WIDTH)-1];

  // no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (write_en) begin
      mem_r[write_index] <= write_word;
    end
  end

  assign read_word = mem_r[read_index];

endmodule

// ---- testbench/fifo_checker_assertions.sv ----
/* flag and bus relations seen at the fifo top ports.
   assumes one pclk domain; bound to the top below. */
module fifo_checker
  import fifo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic write_clock,
  input wire logic output_enable_n,
  input wire logic read_data_oe_n,
  input wire logic full_flag_n,
  input wire logic empty_flag_n,
  input wire logic half_full_flag,
  input wire logic almost_threshold_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst;
    $rose(presetn) |-> full_flag_n && !empty_flag_n && !half_full_flag && almost_threshold_flag;
  endproperty
  a_rst: assert property (p_rst) else $error("flags wrong after reset");
  // three sampling stages on the enable path
  property p_oe; $stable(output_enable_n)[*5] |-> read_data_oe_n == output_enable_n; endproperty
  a_oe: assert property (p_oe) else $error("output enable not followed");
  property p_full_half; !full_flag_n |-> half_full_flag; endproperty
  a_full_half: assert property (p_full_half) else $error("full without half");
  property p_full_alm; !full_flag_n |-> almost_threshold_flag; endproperty
  a_full_alm: assert property (p_full_alm) else $error("full without almost");
  property p_empty; !empty_flag_n |-> full_flag_n && !half_full_flag && almost_threshold_flag;
  endproperty
  a_empty: assert property (p_empty) else $error("empty with wrong flags");
  property p_wr_cause; !write_clock[*8] |=> !$rose(empty_flag_n); endproperty
  a_wr_cause: assert property (p_wr_cause) else $error("empty cleared without write");
  property p_fill; $fell(full_flag_n) |-> $past(half_full_flag) && $past(full_flag_n); endproperty
  a_fill: assert property (p_fill) else $error("full reached from low count");
  property p_rdy; pready |=> !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule

bind dual_clock_fifo fifo_checker i_chk (
  .pclk, .presetn, .pready, .pslverr, .write_clock, .output_enable_n, .read_data_oe_n,
  .full_flag_n, .empty_flag_n, .half_full_flag, .almost_threshold_flag
);

// ---- testbench/fifo_link_model.sv ----
/* writer and reader logic on the far side of the fifo pins.
   assumes pclk from the bench; link clocks stand still between words. */
module fifo_link_model
  import fifo_pkg::*;
(
  input  wire logic                  pclk,
  output logic                       write_clock,
  output logic                       read_clock,
  output logic                       offset_program_n,
  output logic      [WORD_WIDTH-1:0] write_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    write_clock = 1'b0;
    read_clock = 1'b0;
    offset_program_n = 1'b1;
    write_data = '0;
  end
  // one 500 ns link period per word, gap stretches the idle time
  task automatic put(input logic [WORD_WIDTH-1:0] d, input logic p, input int gap);
    write_data <= d;
    offset_program_n <= p;
    repeat (2) @(posedge pclk);
    write_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    write_clock <= 1'b0;
    write_data <= ~d; // released bus never repeats the word
    offset_program_n <= 1'b1;
    repeat (4 + gap) @(posedge pclk);
  endtask
  task automatic get(input int gap);
    read_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    read_clock <= 1'b0;
    repeat (4 + gap) @(posedge pclk);
  endtask
endmodule

// ---- testbench/dual_clock_fifo_tb.sv ----
/* self-checking bench: apb reads, offset programming, fill and drain.
   assumes link model drives the clock, program and data pins, bench drives apb and output_enable_n. */
module dual_clock_fifo_tb
  import fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic write_clock, read_clock, offset_program_n, output_enable_n, read_data_oe_n;
  logic full_flag_n, empty_flag_n, half_full_flag, almost_threshold_flag;
  logic [APB_ADDR_WIDTH-1:0] paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [WORD_WIDTH-1:0]     write_data, read_data, last;
  logic [WORD_WIDTH-1:0]     exp_q[$];
  int                        num_errors, n_checks, cyc;

  dual_clock_fifo i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .write_clock, .read_clock, .offset_program_n, .write_data, .output_enable_n, .read_data,
    .read_data_oe_n, .full_flag_n, .empty_flag_n, .half_full_flag, .almost_threshold_flag
  );
  fifo_link_model i_link (.pclk, .write_clock, .read_clock, .offset_program_n, .write_data);

  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // full_n, empty_n, half, almost for a count n with offsets 5 and 10
  task automatic flags(int n);
    chk("flags", 32'({full_flag_n, empty_flag_n, half_full_flag, almost_threshold_flag}),
        32'({n != 512, n != 0, n >= 256, n <= 5 || n >= 502}));
  endtask

  task automatic t_reset;
    chk("reset flags", 32'({full_flag_n, empty_flag_n, half_full_flag, almost_threshold_flag}),
        32'h9);
    chk("oe_n", 32'(read_data_oe_n), 32'h1);
    apb(1'b0, OFFSET_ADDR, 32'h0);
    chk("default offsets", rd, 32'h4040);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("done t_reset");
  endtask
  task automatic t_program;
    apb(1'b1, CTRL_ADDR, 32'h1);
    i_link.put(18'h00005, 1'b0, 0);
    i_link.put(18'h0000a, 1'b0, 3);
    apb(1'b0, OFFSET_ADDR, 32'h0);
    chk("offsets", rd, 32'h0a05);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("count after program", 32'(rd[9:0]), 32'h0);
    chk("program state", 32'(rd[21:20]), 32'(PROG_DONE));
    apb(1'b1, CTRL_ADDR, 32'h2);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("pause readback", rd, 32'h2);
    i_link.put(18'h12345, 1'b1, 0);
    flags(0);
    apb(1'b1, CTRL_ADDR, 32'h0);
    $display("done t_program");
  endtask
  task automatic t_fill;
    output_enable_n <= 1'b0;
    for (int i = 1; i <= 512; i++) begin
      last = {i[8:0], ~i[8:0]};
      exp_q.push_back(last);
      i_link.put(last, 1'b1, (i % 5 == 0) ? 9 : 0);
      flags(i);
      if (i == 1) chk("fall through", 32'(read_data), 32'(last));
    end
    chk("oe_n low", 32'(read_data_oe_n), 32'h0);
    i_link.put(18'h3ffff, 1'b1, 0);
    flags(512);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("count full", 32'(rd[9:0]), 32'h200);
    $display("done t_fill");
  endtask
  task automatic t_drain;
    for (int i = 511; i >= 0; i--) begin
      last = exp_q.pop_front();
      chk("head word", 32'(read_data), 32'(last));
      i_link.get((i % 7 == 0) ? 11 : 0);
      flags(i);
    end
    i_link.get(0);
    chk("read on empty", 32'(read_data), 32'(last));
    flags(0);
    $display("done t_drain");
  endtask
  task automatic t_flush;
    for (int i = 1; i <= 3; i++) i_link.put(18'h00100 + 18'(i), 1'b1, 0);
    flags(3);
    apb(1'b1, CTRL_ADDR, 32'h1);
    flags(0);
    i_link.put(18'h00077, 1'b1, 0);
    apb(1'b0, OFFSET_ADDR, 32'h0);
    chk("offsets default", rd, 32'h4040);
    chk("head after flush", 32'(read_data), 32'h00077);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("count after flush", 32'(rd[9:0]), 32'h1);
    $display("done t_flush");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    output_enable_n = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset;
    t_program;
    t_fill;
    t_drain;
    t_flush;
    print_verdict;
  end
endmodule
